//--- rtl/lvds_sync_defines.svh
// Register map, field positions, reset values and timing counts of the data interface controllers
`ifndef LVDS_SYNC_DEFINES_SVH
`define LVDS_SYNC_DEFINES_SVH

// ----
// Register offsets
// ----
`define OFS_MODE_CTRL 5'h00
`define OFS_IRQ 5'h01
`define OFS_PROBE 5'h04
`define OFS_SAMPLE 5'h05
`define OFS_LVDS_CTRL 5'h06
`define OFS_PHASE 5'h07
`define OFS_SYNC_CTRL 5'h08
`define OFS_CLK_DIV 5'h16

// ----
// Field positions
// ----
`define BIT_FIFO_EN 2
`define BIT_LVDS_IRQ_EN 3
`define BIT_SYNC_IRQ_EN 2
`define BIT_LVDS_FLAG 7
`define BIT_SYNC_FLAG 6
`define BIT_WATCH 7
`define BIT_SELF_CORRECT 6
`define BIT_SYNC_ERR 7
`define BIT_CHECK 0

// ----
// Reset values
// ----
`define RST_BYTE 8'h00
`define RST_NIBBLE 4'h0
`define RST_OFFSET 2'h0

// ----
// Timing and arithmetic constants
// ----
`define CTL_DIV_BASE 4
`define FILTER_MAX 4'hC
`define FILTER_FRAC 12
`define SERIAL_FRAME 5'h10
`define SERIAL_CMD 5'h08

`endif

//--- rtl/lvds_sync_pkg.sv
// Types shared by the data interface controllers
package lvds_sync_pkg;
    typedef enum logic [4:0] {
        LS_IDLE = 5'b00001,
        LS_SETUP = 5'b00010,
        LS_HOLD = 5'b00100,
        LS_EVAL = 5'b01000,
        LS_HALT = 5'b10000
    } lvds_state_t;

    typedef logic [13:0] sample_t;
endpackage

//--- rtl/lvds_sync_ctrl.sv
// Sampling and synchronisation controllers with serial register port and output buffer
// How it works
// R1: Each controller picks manual, watch or self-correct mode from its own register.
// R2: Manual mode: probes and offsets come only from serial register writes.
// R3: Watch mode measures, filters, compares to threshold (sampling) or critical phase set (sync), flags and halts on violation.
// R4: Register 1 bits 3,2 enable, bits 7,6 flag; enabled flags drive irq.
// R5: A flag clears only after its enable stays zero one controller tick.
// R6: Self-correct mode adopts the new optimum on violation and keeps running.
// R7: Input bits are captured by the delayed strobe set by sample delay.
// R8: Sample delay reg5 7:4, setup probe reg4 7:4, hold probe reg4 3:0, check reg5 bit0.
// R9: Check bit reports the clock copy sampled by the check strobe.
// R10: Software finds setup then hold edge counts by stepping probes until check low.
// R11: Software sets sample delay to half hold minus setup and re-measures.
// R12: Each delay step is a fixed 80 ps, not a clock fraction.
// R13: Sampling watch repeats edge search, filters midpoint, compares to reg6 1:0.
// R14: Software keeps sampling filter length at most 12.
// R15: Reg6 bit7 enables watch; bits 7 and 6 together select self-correct.
// R16: Eight-word FIFO, write counter on strobe, read counter on converter rate.
// R17: Read pointer offset moves the read pointer in steps of two entries.
// R18: Reg7 6:4 reports pointer phase, bit7 sync error; 0/7 critical, 3/4 optimal.
// R19: Reg7 1:0 offset advances read pointer two entries per unit.
// R20: Software enables FIFO in reg0 bit2, reads phase, adjusts offset.
// R21: Sync watch reg8 bit7; select bit0 widens critical set to 0,1,6,7.
// R22: Reg8 bit6 lets the sync controller update the offset itself.
// R23: Phase status is filtered by change over 2^length; length clamps at 12.
// R24: Disabled FIFO is bypassed; enabled adds pointer distance plus four periods.
// R25: Controller tick is sys_clk divided by 2^(reg22 3:0 + 4).
// R26: Flags hold until cleared; a halted controller waits for reconfiguration.
`timescale 1ns/1ps
`include "lvds_sync_defines.svh"

module sample_buffer #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] count_r;
    logic [AW-1:0] wrIdx_r;
    logic [AW-1:0] rdIdx_r;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    assign inReady = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData = mem[rdIdx_r];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wrIdx_r] <= inData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            count_r <= '0;
            wrIdx_r <= '0;
            rdIdx_r <= '0;
        end else begin
            if (push) begin
                wrIdx_r <= wrIdx_r + 1'b1;
            end
            if (pop) begin
                rdIdx_r <= rdIdx_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module lvds_sync_ctrl (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdi,
    output logic sdo,
    output logic sdoOe,
    output logic irq,
    output logic [3:0] sampleDelay,
    output logic [3:0] setupProbeDelay,
    output logic [3:0] holdProbeDelay,
    input wire logic checkIn,
    input wire logic sampleStrobe,
    input wire lvds_sync_pkg::sample_t inputDataBits,
    input wire logic convTick,
    output logic dataValid,
    input wire logic dataReady,
    output lvds_sync_pkg::sample_t dataOut
);
    import lvds_sync_pkg::*;

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    logic fifoEn_r, lvdsIrqEn_r, syncIrqEn_r, lvdsFlag_r, syncFlag_r;
    logic [3:0] sd_r, msd_r, mhd_r, ccd_r;
    logic [7:0] lvdsCtrl_r, syncCtrl_r;
    logic [1:0] phOfs_r;
    logic check_r, syncErr_r;

    // ------------------------------------------------------------------------
    // Serial register port, sampled on sys_clk
    // ------------------------------------------------------------------------
    logic sclkPrev_r;
    logic [4:0] bitCnt_r;
    logic [15:0] shift_r;
    logic [7:0] sdoShift_r;
    logic reading_r;
    logic [7:0] rdData;
    wire sclkRise = sclk && !sclkPrev_r && !csN;
    wire sclkFall = !sclk && sclkPrev_r && !csN;
    wire [15:0] shiftNxt = {shift_r[14:0], sdi};
    wire cmdDone = sclkRise && (bitCnt_r == `SERIAL_CMD - 5'h01);
    wire wrStb = sclkRise && (bitCnt_r == `SERIAL_FRAME - 5'h01) && !shift_r[14];
    wire [4:0] wrAddr = shift_r[11:7];
    wire [7:0] wrData = shiftNxt[7:0];
    wire [4:0] rdAddr = shiftNxt[4:0];
    wire wrIrq = wrStb && (wrAddr == `OFS_IRQ);
    wire wrPhase = wrStb && (wrAddr == `OFS_PHASE);
    wire wrSample = wrStb && (wrAddr == `OFS_SAMPLE);
    wire wrLvds = wrStb && (wrAddr == `OFS_LVDS_CTRL);
    logic [2:0] phaseStat_r;

    always_comb begin
        case (rdAddr)
            `OFS_MODE_CTRL: rdData = {5'h00, fifoEn_r, 2'h0};
            `OFS_IRQ: rdData = {lvdsFlag_r, syncFlag_r, 2'h0, lvdsIrqEn_r, syncIrqEn_r, 2'h0};
            `OFS_PROBE: rdData = {msd_r, mhd_r};
            `OFS_SAMPLE: rdData = {sd_r, 3'h0, check_r}; // see R8, see R9
            `OFS_LVDS_CTRL: rdData = lvdsCtrl_r;
            `OFS_PHASE: rdData = {syncErr_r, phaseStat_r, 2'h0, phOfs_r}; // see R18
            `OFS_SYNC_CTRL: rdData = syncCtrl_r;
            `OFS_CLK_DIV: rdData = {4'h0, ccd_r};
            default: rdData = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst || csN) begin
            bitCnt_r <= '0;
            reading_r <= 1'b0;
            sdoShift_r <= `RST_BYTE;
        end else begin
            if (sclkRise) begin
                bitCnt_r <= bitCnt_r + 5'h01;
                shift_r <= shiftNxt;
            end
            if (cmdDone) begin
                reading_r <= shiftNxt[7];
                sdoShift_r <= rdData;
            end else if (sclkFall && reading_r && bitCnt_r > `SERIAL_CMD) begin
                sdoShift_r <= {sdoShift_r[6:0], 1'b0};
            end
        end
        sclkPrev_r <= srst ? 1'b0 : sclk;
    end

    assign sdo = sdoShift_r[7];
    assign sdoOe = reading_r && !csN;

    // ------------------------------------------------------------------------
    // Controller tick divider
    // ------------------------------------------------------------------------
    logic [19:0] divCnt_r;
    wire [4:0] divExp = 5'(ccd_r) + 5'(`CTL_DIV_BASE);
    wire [19:0] divMask = 20'((21'h1 << divExp) - 21'h1);
    wire ctlTick = ((divCnt_r & divMask) == divMask); // see R25

    always_ff @(posedge sys_clk) begin
        divCnt_r <= srst ? 20'h0 : divCnt_r + 20'h1;
    end

    // ------------------------------------------------------------------------
    // Sampling controller
    // ------------------------------------------------------------------------
    wire lvdsWatch = lvdsCtrl_r[`BIT_WATCH];
    wire lvdsAuto = lvdsWatch && lvdsCtrl_r[`BIT_SELF_CORRECT]; // see R15
    wire [3:0] lvdsFltRaw = lvdsCtrl_r[5:2];
    wire [3:0] lvdsFlt = (lvdsFltRaw > `FILTER_MAX) ? `FILTER_MAX : lvdsFltRaw;
    wire [1:0] lvdsThr = lvdsCtrl_r[1:0];
    lvds_state_t lsState_r;
    logic [3:0] probeCnt_r, setupCnt_r;
    logic signed [19:0] lvdsAvg_r;
    wire scanning = (lsState_r == LS_SETUP) || (lsState_r == LS_HOLD);
    wire signed [19:0] midQ = 20'($signed({1'b0, probeCnt_r} - {1'b0, setupCnt_r}) >>> 1)
                               <<< `FILTER_FRAC;
    wire signed [19:0] lvdsAvgNxt = lvdsAvg_r + ((midQ - lvdsAvg_r) >>> lvdsFlt); // see R13
    wire signed [7:0] drift = 8'(lvdsAvgNxt >>> `FILTER_FRAC);
    wire [7:0] driftMag = drift[7] ? 8'(-drift) : 8'(drift);
    wire lvdsViol = driftMag > {6'h00, lvdsThr};
    wire signed [7:0] sdSum = $signed({4'h0, sd_r}) + drift;
    wire [3:0] sdNew = sdSum[7] ? 4'h0 : (sdSum > 8'sd15 ? 4'hF : sdSum[3:0]);
    wire lvdsCorrect = ctlTick && (lsState_r == LS_HOLD) && (!checkIn || probeCnt_r == 4'hF)
                       && lvdsViol && lvdsAuto;
    wire lvdsEvent = ctlTick && (lsState_r == LS_HOLD) && (!checkIn || probeCnt_r == 4'hF)
                     && lvdsViol && !lvdsAuto;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lsState_r <= LS_IDLE;
            probeCnt_r <= `RST_NIBBLE;
            setupCnt_r <= `RST_NIBBLE;
            lvdsAvg_r <= '0;
        end else if (!lvdsWatch) begin
            lsState_r <= LS_IDLE; // see R26
            lvdsAvg_r <= '0;
        end else if (ctlTick) begin
            case (lsState_r)
                LS_IDLE: begin
                    probeCnt_r <= 4'h0;
                    lsState_r <= LS_SETUP;
                end
                LS_SETUP: begin
                    if (!checkIn || probeCnt_r == 4'hF) begin
                        setupCnt_r <= probeCnt_r;
                        probeCnt_r <= 4'h0;
                        lsState_r <= LS_HOLD;
                    end else begin
                        probeCnt_r <= probeCnt_r + 4'h1;
                    end
                end
                LS_HOLD: begin
                    if (!checkIn || probeCnt_r == 4'hF) begin
                        lvdsAvg_r <= lvdsCorrect ? 20'sd0 : lvdsAvgNxt; // see R6
                        lsState_r <= lvdsEvent ? LS_HALT : LS_EVAL; // see R3
                    end else begin
                        probeCnt_r <= probeCnt_r + 4'h1;
                    end
                end
                LS_EVAL: begin
                    probeCnt_r <= 4'h0;
                    lsState_r <= LS_SETUP;
                end
                LS_HALT: lsState_r <= LS_HALT;
                default: lsState_r <= LS_IDLE;
            endcase
        end
    end

    // Manual mode hands the probe delays to software; watch mode owns them
    assign setupProbeDelay = (scanning && lsState_r == LS_SETUP) ? probeCnt_r
                             : (lvdsWatch ? 4'h0 : msd_r); // see R2, see R10
    assign holdProbeDelay = (scanning && lsState_r == LS_HOLD) ? probeCnt_r
                            : (lvdsWatch ? 4'h0 : mhd_r);
    assign sampleDelay = sd_r; // see R7, see R12

    // ------------------------------------------------------------------------
    // Synchronisation FIFO
    // ------------------------------------------------------------------------
    sample_t syncMem [8];
    sample_t bypass_r;
    logic [2:0] wrPtr_r, rdCnt_r;
    logic bypassValid_r, statValid_r;
    logic bufReady;
    wire [2:0] rdPtr = rdCnt_r + {phOfs_r, 1'b0}; // see R17, see R19
    wire rdAdv = fifoEn_r && convTick && bufReady;
    wire pushValid = fifoEn_r ? rdAdv : bypassValid_r; // see R24
    wire sample_t pushData = fifoEn_r ? syncMem[rdPtr] : bypass_r;

    always_ff @(posedge sys_clk) begin
        if (sampleStrobe) begin
            syncMem[wrPtr_r] <= inputDataBits; // see R16
            bypass_r <= inputDataBits;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !fifoEn_r) begin
            wrPtr_r <= 3'h0;
            rdCnt_r <= 3'h0;
            phaseStat_r <= 3'h0;
            statValid_r <= 1'b0;
        end else begin
            if (sampleStrobe) begin
                wrPtr_r <= wrPtr_r + 3'h1;
            end
            if (rdAdv) begin
                rdCnt_r <= rdCnt_r + 3'h1;
            end
            if (rdAdv && rdPtr == 3'h0) begin
                phaseStat_r <= wrPtr_r; // see R18
                statValid_r <= 1'b1;
            end
        end
        if (srst) begin
            bypassValid_r <= 1'b0;
        end else if (sampleStrobe && !fifoEn_r && bufReady) begin
            bypassValid_r <= 1'b1;
        end else if (bufReady) begin
            bypassValid_r <= 1'b0;
        end
    end

    sample_buffer #(.WIDTH(14), .DEPTH(4)) outBuf (
        .sys_clk(sys_clk),
        .srst(srst),
        .inValid(pushValid),
        .inReady(bufReady),
        .inData(pushData),
        .outValid(dataValid),
        .outReady(dataReady),
        .outData(dataOut)
    );

    // ------------------------------------------------------------------------
    // Synchronisation controller
    // ------------------------------------------------------------------------
    wire syncWatch = syncCtrl_r[`BIT_WATCH];
    wire syncAuto = syncWatch && syncCtrl_r[`BIT_SELF_CORRECT]; // see R22
    wire [3:0] syncFltRaw = syncCtrl_r[5:2];
    wire [3:0] syncFlt = (syncFltRaw > `FILTER_MAX) ? `FILTER_MAX : syncFltRaw; // see R23
    logic signed [19:0] syncAvg_r;
    logic syncHalt_r, syncPrimed_r;
    wire signed [19:0] statQ = 20'($signed({1'b0, phaseStat_r})) <<< `FILTER_FRAC;
    wire signed [19:0] syncAvgNxt = syncAvg_r + ((statQ - syncAvg_r) >>> syncFlt);
    wire [2:0] syncFilt = syncAvgNxt[14:12];
    wire syncCrit = (syncFilt == 3'h0) || (syncFilt == 3'h7)
                    || (syncCtrl_r[0] && (syncFilt == 3'h1 || syncFilt == 3'h6)); // see R21
    wire syncRun = syncWatch && fifoEn_r && statValid_r && !syncHalt_r && ctlTick;
    wire syncEvent = syncRun && syncPrimed_r && syncCrit && !syncAuto;
    wire syncCorrect = syncRun && syncPrimed_r && syncCrit && syncAuto;
    wire [1:0] autoOfs = (syncFilt > 3'h4) ? phOfs_r + 2'h1 : phOfs_r - 2'h1;
    wire crossing = rdAdv && (rdPtr == wrPtr_r);

    always_ff @(posedge sys_clk) begin
        if (srst || !syncWatch) begin
            syncHalt_r <= 1'b0; // see R26
            syncPrimed_r <= 1'b0;
            syncAvg_r <= '0;
        end else if (syncRun) begin
            syncPrimed_r <= 1'b1;
            if (!syncPrimed_r || syncCorrect) begin
                syncAvg_r <= statQ;
            end else begin
                syncAvg_r <= syncAvgNxt;
            end
            if (syncEvent) begin
                syncHalt_r <= 1'b1; // see R3
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt flags and clear qualification
    // ------------------------------------------------------------------------
    logic lvdsEnLowSeen_r, syncEnLowSeen_r;
    wire lvdsClr = ctlTick && lvdsEnLowSeen_r && !lvdsIrqEn_r; // see R5
    wire syncClr = ctlTick && syncEnLowSeen_r && !syncIrqEn_r;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lvdsEnLowSeen_r <= 1'b0;
            syncEnLowSeen_r <= 1'b0;
            lvdsFlag_r <= 1'b0;
            syncFlag_r <= 1'b0;
        end else begin
            if (ctlTick) begin
                lvdsEnLowSeen_r <= !lvdsIrqEn_r;
                syncEnLowSeen_r <= !syncIrqEn_r;
            end
            lvdsFlag_r <= lvdsEvent || (lvdsFlag_r && !lvdsClr); // see R26
            syncFlag_r <= syncEvent || (syncFlag_r && !syncClr);
        end
    end

    assign irq = (lvdsFlag_r && lvdsIrqEn_r) || (syncFlag_r && syncIrqEn_r); // see R4

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fifoEn_r <= 1'b0;
            lvdsIrqEn_r <= 1'b0;
            syncIrqEn_r <= 1'b0;
            sd_r <= `RST_NIBBLE;
            msd_r <= `RST_NIBBLE;
            mhd_r <= `RST_NIBBLE;
            ccd_r <= `RST_NIBBLE;
            lvdsCtrl_r <= `RST_BYTE;
            syncCtrl_r <= `RST_BYTE;
            phOfs_r <= `RST_OFFSET;
            check_r <= 1'b0;
            syncErr_r <= 1'b0;
        end else begin
            check_r <= checkIn; // see R9
            if (wrStb && wrAddr == `OFS_MODE_CTRL) begin
                fifoEn_r <= wrData[`BIT_FIFO_EN]; // see R20
            end
            if (wrIrq) begin
                lvdsIrqEn_r <= wrData[`BIT_LVDS_IRQ_EN];
                syncIrqEn_r <= wrData[`BIT_SYNC_IRQ_EN];
            end
            if (wrStb && wrAddr == `OFS_PROBE) begin
                msd_r <= wrData[7:4]; // see R8
                mhd_r <= wrData[3:0];
            end
            if (wrSample) begin
                sd_r <= wrData[7:4];
            end else if (lvdsCorrect) begin
                sd_r <= sdNew; // see R6
            end
            if (wrLvds) begin
                lvdsCtrl_r <= wrData; // see R1
            end
            if (wrStb && wrAddr == `OFS_SYNC_CTRL) begin
                syncCtrl_r <= wrData;
            end
            if (wrStb && wrAddr == `OFS_CLK_DIV) begin
                ccd_r <= wrData[3:0];
            end
            if (wrPhase) begin
                phOfs_r <= wrData[1:0]; // see R2
            end else if (syncCorrect) begin
                phOfs_r <= autoOfs; // see R22
            end
            syncErr_r <= crossing || (syncErr_r && !(wrPhase && wrData[`BIT_SYNC_ERR]));
        end
    end
endmodule

//--- testbench/lvds_sync_ctrl_asserts.sv
// Port-level assertions for the data interface controllers
`timescale 1ns/1ps
module lvds_sync_ctrl_asserts (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdo,
    input wire logic sdoOe,
    input wire logic irq,
    input wire logic [3:0] sampleDelay,
    input wire logic sampleStrobe,
    input wire logic convTick,
    input wire logic dataValid,
    input wire logic dataReady,
    input wire lvds_sync_pkg::sample_t dataOut
);
    import lvds_sync_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // ----
    // Properties
    // ----
    a_reset_quiet: assert property ($fell(srst) |-> !irq && !sdoOe && !dataValid)
        else $error("outputs busy after reset");
    a_reset_delay: assert property ($fell(srst) |-> sampleDelay == 4'h0)
        else $error("sample delay not cleared by reset");
    a_oe_selected: assert property (sdoOe |-> !csN)
        else $error("sdo driven without chip select");
    a_oe_rise_high: assert property ($rose(sdoOe) |-> sclk)
        else $error("sdo enabled away from serial rise");
    a_sdo_shift_low: assert property (sdoOe && $past(sdoOe) && $changed(sdo) |-> !sclk)
        else $error("sdo changed while serial clock high");
    a_sdo_still_high: assert property (sdoOe && $past(sdoOe) && sclk && $past(sclk) |->
        $stable(sdo)) else $error("sdo moved during serial clock high");
    a_hold_word: assert property (dataValid && !dataReady |=>
        dataValid && $stable(dataOut)) else $error("output word lost while stalled");
    a_valid_cause: assert property ($rose(dataValid) |->
        $past(sampleStrobe, 2) || $past(convTick)) else $error("output word without source");
    c_pop: cover property (dataValid && dataReady);
    c_irq: cover property ($rose(irq));
    c_read: cover property ($rose(sdoOe));
endmodule

bind lvds_sync_ctrl lvds_sync_ctrl_asserts chk (.sys_clk(sys_clk), .srst(srst), .sclk(sclk),
    .csN(csN), .sdo(sdo), .sdoOe(sdoOe), .irq(irq), .sampleDelay(sampleDelay),
    .sampleStrobe(sampleStrobe), .convTick(convTick), .dataValid(dataValid),
    .dataReady(dataReady), .dataOut(dataOut));

//--- testbench/lvds_source_model.sv
// Behavioural LVDS data source with the check sampler's eye model
`timescale 1ns/1ps
module lvds_source_model #(
    parameter int LEAD = 3,
    parameter int TRAIL = 9
) (
    input wire logic sys_clk,
    input wire logic run,
    input wire logic fifoRun,
    input wire logic [3:0] eyeShift,
    input wire logic [3:0] sampleDelay,
    input wire logic [3:0] setupProbeDelay,
    input wire logic [3:0] holdProbeDelay,
    output logic checkIn,
    output logic sampleStrobe,
    output lvds_sync_pkg::sample_t inputDataBits,
    output logic convTick
);
    import lvds_sync_pkg::*;
    int lead;
    int trail;
    logic [1:0] phase = 2'h0;
    sample_t word = 14'h0100;
    // ----
    // Eye edges counted in delay steps around the sample strobe
    // ----
    assign lead = int'(sampleDelay) - int'(setupProbeDelay) + LEAD - int'(eyeShift);
    assign trail = int'(sampleDelay) + int'(holdProbeDelay) - TRAIL - int'(eyeShift);
    assign checkIn = (lead > 0) && (trail < 0);
    assign sampleStrobe = run && (phase == 2'h0);
    assign convTick = fifoRun && (phase == 2'h2);
    // Bus shows junk between strobes
    assign inputDataBits = sampleStrobe ? word : ~word;
    always_ff @(posedge sys_clk) begin
        phase <= phase + 2'h1;
        if (!run) begin
            word <= 14'h0100;
        end else if (sampleStrobe) begin
            word <= word + 14'h0001;
        end
    end
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the data interface controllers
`timescale 1ns/1ps
module tb_top;
    import lvds_sync_pkg::*;
    localparam int LEAD = 3;
    localparam int TRAIL = 9;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic sclk = 1'b0;
    logic csN = 1'b1;
    logic sdi = 1'b0;
    logic dataReady = 1'b1;
    logic run = 1'b0;
    logic fifoRun = 1'b0;
    logic [3:0] eyeShift = 4'h0;
    logic sdo, sdoOe, irq, checkIn, sampleStrobe, convTick, dataValid;
    logic [3:0] sampleDelay, setupProbeDelay, holdProbeDelay;
    sample_t inputDataBits, dataOut;
    logic [7:0] rd;
    logic [2:0] stat;
    int num_errors = 0;
    int samples_checked = 0;
    int setupCnt, holdCnt, i;

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    lvds_sync_ctrl dut (.sys_clk(sys_clk), .srst(srst), .sclk(sclk), .csN(csN), .sdi(sdi),
        .sdo(sdo), .sdoOe(sdoOe), .irq(irq), .sampleDelay(sampleDelay),
        .setupProbeDelay(setupProbeDelay), .holdProbeDelay(holdProbeDelay), .checkIn(checkIn),
        .sampleStrobe(sampleStrobe), .inputDataBits(inputDataBits), .convTick(convTick),
        .dataValid(dataValid), .dataReady(dataReady), .dataOut(dataOut));
    lvds_source_model #(.LEAD(LEAD), .TRAIL(TRAIL)) partner (.sys_clk(sys_clk), .run(run),
        .fifoRun(fifoRun), .eyeShift(eyeShift), .sampleDelay(sampleDelay),
        .setupProbeDelay(setupProbeDelay), .holdProbeDelay(holdProbeDelay), .checkIn(checkIn),
        .sampleStrobe(sampleStrobe), .inputDataBits(inputDataBits), .convTick(convTick));

    // ----
    // Tasks
    // ----
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic xfer(input logic rw, input logic [4:0] addr, input logic [7:0] wd);
        logic [15:0] frame;
        frame = {rw, 2'b00, addr, wd};
        csN = 1'b0;
        for (int b = 15; b >= 0; b--) begin
            sdi = frame[b];
            sclk = 1'b0;
            tick(2);
            if (b < 8) rd[b] = sdo;
            sclk = 1'b1;
            tick(2);
        end
        sclk = 1'b0;
        tick(2);
        csN = 1'b1;
        tick(2);
    endtask

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----
    // Sequence
    // ----
    initial begin
        tick(3);
        srst = 1'b0;
        tick(1);
        xfer(1'b1, 5'h06, 8'h00);
        check(rd, 8'h00, "ctrl reset value");
        xfer(1'b1, 5'h03, 8'h00);
        check(rd, 8'h00, "unmapped read");
        xfer(1'b0, 5'h16, 8'h00);
        xfer(1'b0, 5'h04, 8'hA5);
        check({setupProbeDelay, holdProbeDelay}, 8'hA5, "probe ports");
        xfer(1'b0, 5'h05, 8'hF1);
        check(sampleDelay, 4'hF, "sample delay port");
        xfer(1'b1, 5'h05, 8'h00);
        check(rd, 8'hF0, "check bit readback");
        xfer(1'b0, 5'h05, 8'h00);
        for (setupCnt = 0; setupCnt < 15; setupCnt++) begin
            xfer(1'b0, 5'h04, {setupCnt[3:0], 4'h0});
            xfer(1'b1, 5'h05, 8'h00);
            if (rd[0] === 1'b0) break;
        end
        check(setupCnt, LEAD, "setup edge");
        for (holdCnt = 0; holdCnt < 15; holdCnt++) begin
            xfer(1'b0, 5'h04, {4'h0, holdCnt[3:0]});
            xfer(1'b1, 5'h05, 8'h00);
            if (rd[0] === 1'b0) break;
        end
        check(holdCnt, TRAIL, "hold edge");
        xfer(1'b0, 5'h05, {4'((holdCnt - setupCnt) / 2), 4'h0});
        check(sampleDelay, (TRAIL - LEAD) / 2, "centred delay");
        // Eye drifts by two steps; watch mode must flag and halt
        xfer(1'b0, 5'h04, 8'h00);
        eyeShift = 4'h2;
        xfer(1'b0, 5'h01, 8'h08);
        xfer(1'b0, 5'h06, 8'h81);
        for (i = 0; i < 3000 && irq !== 1'b1; i++) tick(1);
        check(irq, 1'b1, "drift irq");
        if (i == 3000) conclude();
        xfer(1'b1, 5'h01, 8'h00);
        check(rd, 8'h88, "flag and enable");
        check(sampleDelay, (TRAIL - LEAD) / 2, "halted delay");
        xfer(1'b0, 5'h01, 8'h00);
        check(irq, 1'b0, "masked irq");
        tick(40);
        xfer(1'b1, 5'h01, 8'h00);
        check(rd, 8'h00, "flag cleared");
        xfer(1'b0, 5'h06, 8'h00);
        xfer(1'b0, 5'h06, 8'hC1);
        for (i = 0; i < 3000 && sampleDelay !== 4'h5; i++) tick(1);
        check(sampleDelay, (TRAIL - LEAD) / 2 + 2, "corrected delay");
        if (i == 3000) conclude();
        xfer(1'b1, 5'h01, 8'h00);
        check(rd, 8'h00, "no flag in self-correct");
        xfer(1'b0, 5'h06, 8'h00);
        // Bypass: stall until full, then drain
        dataReady = 1'b0;
        run = 1'b1;
        tick(40);
        run = 1'b0;
        tick(4);
        dataReady = 1'b1;
        for (i = 0; i < 4; i++) begin
            check(dataValid, 1'b1, "buffered valid");
            check(dataOut, 14'h0100 + i, "buffered word");
            tick(1);
        end
        check(dataValid, 1'b0, "buffer drained");
        // FIFO on: offset one lowers phase status by two
        run = 1'b1;
        fifoRun = 1'b1;
        xfer(1'b0, 5'h00, 8'h04);
        tick(64);
        xfer(1'b1, 5'h07, 8'h00);
        stat = rd[6:4];
        xfer(1'b0, 5'h07, 8'h01);
        tick(64);
        xfer(1'b1, 5'h07, 8'h00);
        check(rd[6:4], 3'(stat - 3'h2), "phase after offset");
        check(rd[1:0], 2'h1, "offset field");
        xfer(1'b0, 5'h01, 8'h04);
        xfer(1'b0, 5'h08, 8'h81);
        tick(64);
        check(irq, 1'b1, "sync irq");
        conclude();
    end
endmodule
